/* rtl/bsspio_pkg.sv */
// Purpose: Shared constants and types of the split-port burst SRAM link.
// Assumes: One width variant is chosen here for both ends.
// Notes: Storage depth is kept small; high address bits alias.
package bsspio_pkg;

    // Width variant: 1 selects the 8-bit part with nibble lanes.
    localparam bit X8_VARIANT = 1'b0;
    // Data width, lane count and lane width of the chosen variant.
    localparam int DATA_W = X8_VARIANT ? 8 : 36;
    localparam int LANES = X8_VARIANT ? 2 : 4;
    localparam int LANE_W = DATA_W / LANES;
    // Select pin counts on the link.
    localparam int NIBBLE_LANES = 2;
    localparam int BYTE_LANES = 4;
    // Address width: 21 for x8 and x9, 20 for x18, 19 for x36.
    localparam int ADDR_W = X8_VARIANT ? 21 : 19;
    // Words per burst and the width of a word index.
    localparam int BURST_LEN = 4;
    localparam int WORD_W = 2;
    // Locations held in flops; the address low bits index them.
    localparam int MEM_IDX_W = 4;
    localparam int MEM_DEPTH = 1 << MEM_IDX_W;
    // Controller clock and its divide ratio to the link clock.
    localparam int CLK_PERIOD_NS = 8;
    localparam int LINK_DIV = 4;
    localparam int LINK_PERIOD_NS = CLK_PERIOD_NS * LINK_DIV;
    // Upper frequency with the timing loop switched off.
    localparam int SLOW_MODE_MAX_MHZ = 167;
    // First read beat delay in half link cycles, loop on and off.
    localparam int LAT_HALF_LOOP = 3;
    localparam int LAT_HALF_NOLOOP = 2;
    // Controller edges from a beat launch to its use after sync.
    localparam int RD_SYNC_EDGES = 3;
    // Read expectation pipeline length and beat tap pattern.
    localparam int RD_PIPE_W = 16;
    localparam logic [7:0] BEAT_PATTERN = 8'h55;
    localparam logic [RD_PIPE_W-1:0] TAP_MASK_LOOP =
        RD_PIPE_W'(BEAT_PATTERN) << (2 * LAT_HALF_LOOP + RD_SYNC_EDGES);
    localparam logic [RD_PIPE_W-1:0] TAP_MASK_NOLOOP =
        RD_PIPE_W'(BEAT_PATTERN) << (2 * LAT_HALF_NOLOOP + RD_SYNC_EDGES);
    // Divider phase after reset and the two data update slots.
    localparam logic [1:0] PH_RST = 2'h3;
    localparam logic [1:0] SLOT_K = 2'h2;
    localparam logic [1:0] SLOT_KN = 2'h0;
    // Reset level of mode synchronisers.
    localparam logic SYNC_RST = 1'b0;

    // Burst progress of a port inside the device.
    typedef enum logic [2:0] {
        PH_IDLE   = 3'b001,
        PH_FIRST  = 3'b010,
        PH_SECOND = 3'b100
    } bsspio_ph_t;

    // Controller beat sequencer.
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_B1   = 4'b0010,
        HS_B2   = 4'b0100,
        HS_B3   = 4'b1000
    } bsspio_hs_t;

endpackage

/* rtl/bsspio_if.sv */
// Purpose: Pin bundle between memory controller and burst SRAM.
// Assumes: The controller drives the link clocks; the SRAM drives read data and the echo clocks.
// Notes: The read bus level is resolved here from the driver enable.
`timescale 1ns/100ps
interface bsspio_if;
    import bsspio_pkg::*;

    logic                    k;                       // Input clock.
    logic                    k_n;                     // Its complement.
    logic                    c;                       // Output clock.
    logic                    c_n;                     // Its complement.
    logic [ADDR_W-1:0]       addr;                    // Shared address.
    logic                    read_port_sel_n;         // Read start.
    logic                    write_port_sel_n;        // Write start.
    logic [DATA_W-1:0]       d;                       // Write data.
    logic [BYTE_LANES-1:0]   byte_lane_write_sel_n;   // Lane enables.
    logic [NIBBLE_LANES-1:0] nibble_lane_write_sel_n; // x8 enables.
    logic                    timing_loop_disable_n;   // Loop on when high.
    logic                    single_clock_mode;       // Use K for output.
    logic [DATA_W-1:0]       q_out;                   // Driven read data.
    logic                    q_oe;                    // Read driver on.
    logic                    echo_timebase;           // Echo clock.
    logic                    echo_timebase_n;         // Its complement.
    wire  [DATA_W-1:0]       q;                       // Read bus level.

    // Termination pulls the read bus high while the SRAM releases it.
    assign q = q_oe ? q_out : {DATA_W{1'b1}};

    modport dev (
        input  k, k_n, c, c_n, addr, read_port_sel_n, write_port_sel_n,
        input  d, byte_lane_write_sel_n, nibble_lane_write_sel_n,
        input  timing_loop_disable_n, single_clock_mode,
        output q_out, q_oe, echo_timebase, echo_timebase_n
    );

    modport ctl (
        output k, k_n, c, c_n, addr, read_port_sel_n, write_port_sel_n,
        output d, byte_lane_write_sel_n, nibble_lane_write_sel_n,
        output timing_loop_disable_n, single_clock_mode,
        input  q, echo_timebase, echo_timebase_n
    );

endinterface

/* rtl/bsspio_dev.sv */
// Purpose: SRAM end of the split-port burst link, clocked by the link.
// Assumes: C rises together with K; mode pins are static while running.
// Notes: Read beats leave through a half-cycle output mux (DDR).
// Functional notes
// - x8 nibble selects gate bits 3..0, 7..4.
// - Deselected nibble is not written.
// - Byte selects gate 9-bit lanes per beat.
// - Deselected byte lane keeps stored contents.
// - One address bus, sampled on K rise.
// - Address width follows four sub-array organisation.
// - Address ignored when addressed port deselected.
// - Read beats launch on C pair, else K.
// - Deselect finishes burst, then outputs float.
// - Low read select on K starts read.
// - Each read returns four sequential words.
// - Data and lane selects captured on K and K#.
// - Accesses start only on K rise.
// - Controller drives output clocks that launch data.
// - Echo clock runs free with output clock.
// - Low write select on K starts write.
// - Loop off selects older one-cycle timing.
`timescale 1ns/100ps
module bsspio_dev
    import bsspio_pkg::*;
(
    bsspio_if.dev     link,
    input  wire logic rst_n
);

    // Output launch clocks: the C pair, or the K pair in single mode.
    wire logic oclk;
    wire logic oclk_n;

    // Stored bursts: four words per location.
    logic [DATA_W-1:0]    mem [MEM_DEPTH][BURST_LEN];

    // Read port state in the K domain.
    bsspio_ph_t           rd_ph_reg;
    bsspio_ph_t           rd_ph_next;
    logic [MEM_IDX_W-1:0] rd_idx_reg;   // Location being read.

    // Write port state in the K domain.
    bsspio_ph_t           wr_ph_reg;
    bsspio_ph_t           wr_ph_next;
    logic [MEM_IDX_W-1:0] wr_idx_reg;   // Location being written.
    logic [DATA_W-1:0]    kbeat_reg;    // Beat caught on K rise.
    logic [LANES-1:0]     ksel_reg;     // Its lane selects.

    // Beat caught on K# rise.
    logic [DATA_W-1:0]    nbeat_reg;
    logic [LANES-1:0]     nsel_reg;

    // Output-clock domain: pair hold, rising-edge beat and enable.
    logic                 hold_v_reg;   // Hold pair is a live read.
    logic [DATA_W-1:0]    even_hold_reg;
    logic [DATA_W-1:0]    odd_hold_reg;
    logic [DATA_W-1:0]    q_pos_reg;
    logic                 pos_en_reg;
    logic                 loop_c1_reg;  // Loop pin sync, first stage.
    logic                 loop_c2_reg;  // Loop pin sync, second stage.

    // Complement output-clock domain.
    logic [DATA_W-1:0]    q_neg_reg;
    logic                 neg_en_reg;
    logic                 loop_n1_reg;
    logic                 loop_n2_reg;

    // Clock selection for the read launch path and the echo clock.
    assign oclk   = link.single_clock_mode ? link.k   : link.c;
    assign oclk_n = link.single_clock_mode ? link.k_n : link.c_n;

    // The echo clock follows the launch clock and never stops.
    assign link.echo_timebase   = oclk;
    assign link.echo_timebase_n = oclk_n;

    // A read is taken on a K rise unless its burst is mid-way.
    wire logic rd_take = !link.read_port_sel_n
                         && (rd_ph_reg != PH_FIRST);

    // A write is taken likewise; a read on the same edge wins the bus.
    wire logic wr_take = !link.write_port_sel_n && !rd_take
                         && (wr_ph_reg != PH_FIRST);

    // Low address bits pick a location within the sub-arrays.
    wire logic [MEM_IDX_W-1:0] idx_in =
        link.addr[MEM_IDX_W-1:0];

    // Lane selects of the chosen variant.
    wire logic [LANES-1:0] lane_sel_n = X8_VARIANT
        ? LANES'(link.nibble_lane_write_sel_n)
        : LANES'(link.byte_lane_write_sel_n);

    // Even beats are caught on the command edge and the one after.
    wire logic kbeat_load = wr_take || (wr_ph_reg == PH_FIRST);

    // Commit words 0,1 in the first cycle and 2,3 in the second.
    wire logic                 wr_commit = (wr_ph_reg != PH_IDLE);
    wire logic [WORD_W-1:0]    wr_word   =
        (wr_ph_reg == PH_SECOND) ? 2'h2 : 2'h0;

    // Current read pair; valid while the read burst is in progress.
    wire logic                 cur_v   = (rd_ph_reg != PH_IDLE);
    wire logic [WORD_W-1:0]    rd_word =
        (rd_ph_reg == PH_SECOND) ? 2'h2 : 2'h0;
    wire logic [DATA_W-1:0]    cur_even = mem[rd_idx_reg][rd_word];
    wire logic [DATA_W-1:0]    cur_odd  = mem[rd_idx_reg][rd_word + 2'h1];

    // Burst sequencing of both ports.
    always_comb
    begin
        unique case (rd_ph_reg)
            PH_IDLE, PH_SECOND: rd_ph_next = rd_take ? PH_FIRST : PH_IDLE;
            PH_FIRST:           rd_ph_next = PH_SECOND;
            default:            rd_ph_next = PH_IDLE;
        endcase
        unique case (wr_ph_reg)
            PH_IDLE, PH_SECOND: wr_ph_next = wr_take ? PH_FIRST : PH_IDLE;
            PH_FIRST:           wr_ph_next = PH_SECOND;
            default:            wr_ph_next = PH_IDLE;
        endcase
    end

    // K-domain control: port state, addresses and even write beats.
    always_ff @(posedge link.k or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_ph_reg  <= PH_IDLE;
            wr_ph_reg  <= PH_IDLE;
            rd_idx_reg <= '0;
            wr_idx_reg <= '0;
            kbeat_reg  <= '0;
            ksel_reg   <= '1;
        end
        else
        begin
            rd_ph_reg <= rd_ph_next;
            wr_ph_reg <= wr_ph_next;
            // Addresses are kept only for a selected port.
            if (rd_take)
                rd_idx_reg <= idx_in;
            if (wr_take)
                wr_idx_reg <= idx_in;
            // Data and selects ride with the beat on this edge.
            if (kbeat_load)
            begin
                kbeat_reg <= link.d;
                ksel_reg  <= lane_sel_n;
            end
        end
    end

    // Odd write beats are caught on every K# rise; used only in bursts.
    always_ff @(posedge link.k_n or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nbeat_reg <= '0;
            nsel_reg  <= '1;
        end
        else
        begin
            nbeat_reg <= link.d;
            nsel_reg  <= lane_sel_n;
        end
    end

    // Array update: a lane with a high select keeps its old value.
    always_ff @(posedge link.k)
    begin
        if (wr_commit)
        begin
            for (int l = 0; l < LANES; l++)
            begin
                if (!ksel_reg[l])
                    mem[wr_idx_reg][wr_word][l*LANE_W +: LANE_W] <=
                        kbeat_reg[l*LANE_W +: LANE_W];
                if (!nsel_reg[l])
                    mem[wr_idx_reg][wr_word + 2'h1][l*LANE_W +: LANE_W] <=
                        nbeat_reg[l*LANE_W +: LANE_W];
            end
        end
    end

    // Rising launch edge: hold the pair, launch even or odd word.
    // With the loop on, the first beat moves to the complement edge.
    always_ff @(posedge oclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loop_c1_reg   <= SYNC_RST;
            loop_c2_reg   <= SYNC_RST;
            hold_v_reg    <= 1'b0;
            even_hold_reg <= '0;
            odd_hold_reg  <= '0;
            q_pos_reg     <= '0;
            pos_en_reg    <= 1'b0;
        end
        else
        begin
            loop_c1_reg   <= link.timing_loop_disable_n;
            loop_c2_reg   <= loop_c1_reg;
            hold_v_reg    <= cur_v;
            even_hold_reg <= cur_even;
            odd_hold_reg  <= cur_odd;
            if (loop_c2_reg)
            begin
                // Loop on: odd words leave on the rising edge.
                q_pos_reg  <= odd_hold_reg;
                pos_en_reg <= hold_v_reg;
            end
            else
            begin
                // Loop off: word 0 leaves one cycle after the command.
                q_pos_reg  <= cur_even;
                pos_en_reg <= cur_v;
            end
        end
    end

    // Complement launch edge: the other word of the held pair.
    always_ff @(posedge oclk_n or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loop_n1_reg <= SYNC_RST;
            loop_n2_reg <= SYNC_RST;
            q_neg_reg   <= '0;
            neg_en_reg  <= 1'b0;
        end
        else
        begin
            loop_n1_reg <= link.timing_loop_disable_n;
            loop_n2_reg <= loop_n1_reg;
            q_neg_reg   <= loop_n2_reg ? even_hold_reg
                                       : odd_hold_reg;
            neg_en_reg  <= hold_v_reg;
        end
    end

    // Each half cycle shows the flop of the edge that began it.
    // The enable drops on the first launch edge after the burst.
    assign link.q_out = oclk ? q_pos_reg : q_neg_reg;
    assign link.q_oe  = oclk ? pos_en_reg : neg_en_reg;

endmodule // bsspio_dev

/* rtl/bsspio_ctl.sv */
// Purpose: Controller end: makes the link clocks and runs bursts.
// Assumes: Mode inputs stay static while commands run.
// Notes: Link clock is clk divided by four; data change mid-phase.
`timescale 1ns/100ps
module bsspio_ctl
    import bsspio_pkg::*;
(
    bsspio_if.ctl                           link,
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       cmd_valid,
    output logic                            cmd_ready,
    input  wire logic                       cmd_write,
    input  wire logic [ADDR_W-1:0]          cmd_addr,
    input  wire logic [BURST_LEN*DATA_W-1:0] cmd_wdata,
    input  wire logic [BURST_LEN*LANES-1:0] cmd_wsel_n,
    output logic                            rd_valid,
    output logic [BURST_LEN*DATA_W-1:0]     rd_data,
    input  wire logic                       cfg_single_clock,
    input  wire logic                       cfg_timing_loop_disable_n
);

    logic [1:0]                  ph_reg;        // Divider phase.
    logic [1:0]                  ph_next;
    logic                        k_reg;         // Link clock pair.
    logic                        kn_reg;
    bsspio_hs_t                  state_reg;     // Beat sequencer.
    bsspio_hs_t                  state_next;
    logic                        ready_reg;
    logic [ADDR_W-1:0]           addr_reg;
    logic                        rsel_n_reg;
    logic                        wsel_n_reg;
    logic [DATA_W-1:0]           d_reg;
    logic [LANES-1:0]            lsel_reg;      // Lane selects driven.
    logic [BURST_LEN*DATA_W-1:0] wdata_reg;     // Held burst data.
    logic [BURST_LEN*LANES-1:0]  wsel_reg;      // Held burst selects.
    logic                        single_reg;
    logic                        loop_reg;
    logic [RD_PIPE_W-1:0]        pipe_reg;      // Expected read beats.
    logic [DATA_W-1:0]           q_s1_reg;      // Read bus sync.
    logic [DATA_W-1:0]           q_s2_reg;
    logic [BURST_LEN*DATA_W-1:0] gather_reg;
    logic [WORD_W-1:0]           gcnt_reg;      // Beats gathered.
    logic                        rd_valid_reg;
    logic [BURST_LEN*DATA_W-1:0] rd_data_reg;

    // Phase slots: K-beat data set before K rise, K#-beat before K#.
    assign ph_next = ph_reg + 2'h1;
    wire logic slot_k  = (ph_reg == SLOT_K);
    wire logic slot_kn = (ph_reg == SLOT_KN);
    wire logic take    = cmd_valid && ready_reg;
    wire logic adv     = ((state_reg == HS_B1) && slot_kn)
                      || ((state_reg == HS_B2) && slot_k)
                      || ((state_reg == HS_B3) && slot_kn);
    wire logic [WORD_W-1:0] widx = (state_reg == HS_B1) ? 2'h1
                                 : (state_reg == HS_B2) ? 2'h2 : 2'h3;
    wire logic [RD_PIPE_W-1:0] tap_mask = loop_reg ? TAP_MASK_LOOP
                                                   : TAP_MASK_NOLOOP;
    wire logic sample = |(pipe_reg & tap_mask);

    // Beat sequencer: one command per two link cycles.
    always_comb
    begin
        unique case (state_reg)
            HS_IDLE: state_next = take ? HS_B1 : HS_IDLE;
            HS_B1:   state_next = slot_kn ? HS_B2 : HS_B1;
            HS_B2:   state_next = slot_k ? HS_B3 : HS_B2;
            HS_B3:   state_next = slot_kn ? HS_IDLE : HS_B3;
            default: state_next = HS_IDLE;
        endcase
    end

    // Link clocks, commands and write beats.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph_reg     <= PH_RST;
            k_reg      <= 1'b0;
            kn_reg     <= 1'b1;
            state_reg  <= HS_IDLE;
            ready_reg  <= 1'b0;
            addr_reg   <= '0;
            rsel_n_reg <= 1'b1;
            wsel_n_reg <= 1'b1;
            d_reg      <= '0;
            lsel_reg   <= '1;
            wdata_reg  <= '0;
            wsel_reg   <= '1;
            single_reg <= 1'b0;
            loop_reg   <= 1'b1;
        end
        else
        begin
            ph_reg     <= ph_next;
            k_reg      <= !ph_next[1];
            kn_reg     <= ph_next[1];
            state_reg  <= state_next;
            ready_reg  <= (state_next == HS_IDLE) && (ph_next == SLOT_K);
            single_reg <= cfg_single_clock;
            loop_reg   <= cfg_timing_loop_disable_n;
            if (take)
            begin
                // Select stands over one K rise only; the address holds until the next command.
                addr_reg   <= cmd_addr;
                rsel_n_reg <= cmd_write;
                wsel_n_reg <= !cmd_write;
                wdata_reg  <= cmd_wdata;
                // Reads hold every lane select high for all beats.
                wsel_reg   <= cmd_write ? cmd_wsel_n
                                        : {BURST_LEN*LANES{1'b1}};
                d_reg      <= cmd_wdata[DATA_W-1:0];
                lsel_reg   <= cmd_write ? cmd_wsel_n[LANES-1:0]
                                        : {LANES{1'b1}};
            end
            else if (adv)
            begin
                rsel_n_reg <= 1'b1;
                wsel_n_reg <= 1'b1;
                d_reg      <= wdata_reg[widx*DATA_W +: DATA_W];
                // The port select is released by now; the device's burst state,
                // not these held selects, tells a write beat from a read.
                lsel_reg   <= wsel_reg[widx*LANES +: LANES];
            end
        end
    end

    // Read return: sync the bus, take beats at expected edges.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pipe_reg     <= '0;
            q_s1_reg     <= '0;
            q_s2_reg     <= '0;
            gather_reg   <= '0;
            gcnt_reg     <= '0;
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= '0;
        end
        else
        begin
            pipe_reg     <= {pipe_reg[RD_PIPE_W-2:0], take && !cmd_write};
            q_s1_reg     <= link.q;
            q_s2_reg     <= q_s1_reg;
            rd_valid_reg <= 1'b0;
            if (sample)
            begin
                // Word 0 ends in the low bits after four beats.
                gather_reg <= {q_s2_reg,
                    gather_reg[BURST_LEN*DATA_W-1:DATA_W]};
                gcnt_reg   <= gcnt_reg + 2'h1;
                if (gcnt_reg == 2'h3)
                begin
                    rd_valid_reg <= 1'b1;
                    rd_data_reg  <= {q_s2_reg,
                        gather_reg[BURST_LEN*DATA_W-1:DATA_W]};
                end
            end
        end
    end

    // Pins and user outputs straight from flops.
    assign link.k                       = k_reg;
    assign link.k_n                     = kn_reg;
    assign link.c                       = k_reg;
    assign link.c_n                     = kn_reg;
    assign link.addr                    = addr_reg;
    assign link.read_port_sel_n         = rsel_n_reg;
    assign link.write_port_sel_n        = wsel_n_reg;
    assign link.d                       = d_reg;
    assign link.byte_lane_write_sel_n   = X8_VARIANT ? {BYTE_LANES{1'b1}}
        : BYTE_LANES'(lsel_reg);
    assign link.nibble_lane_write_sel_n = X8_VARIANT
        ? NIBBLE_LANES'(lsel_reg) : {NIBBLE_LANES{1'b1}};
    assign link.timing_loop_disable_n   = loop_reg;
    assign link.single_clock_mode       = single_reg;
    assign cmd_ready                    = ready_reg;
    assign rd_valid                     = rd_valid_reg;
    assign rd_data                      = rd_data_reg;

endmodule // bsspio_ctl

/* dv/bsspio_properties.sv */
// Purpose: Pin-timing checks on the split-port burst SRAM link.
// Assumes: Sampled on clk; the link clock is clk divided by four.
// Notes: Figures in clk cycles hold with the timing loop on or off.
`timescale 1ns/100ps
module bsspio_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic read_port_sel_n,
    input wire logic write_port_sel_n,
    input wire logic single_clock_mode,
    input wire logic q_oe,
    input wire logic echo_timebase
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // One whole link period: two clk high, two low, high again.
    sequence s_k_period; k[*2] ##1 (!k)[*2] ##1 k; endsequence
    // A burst of four half-cycle beats keeps the driver on 8 clk.
    sequence s_burst; q_oe[*8]; endsequence
    property p_echo; echo_timebase == (single_clock_mode ? k : c); endproperty
    a_echo: assert property (p_echo) else $error("echo clock off");
    property p_kn; k_n == !k; endproperty
    a_kn: assert property (p_kn) else $error("clock pair skewed");
    property p_kdiv; $rose(k) |-> s_k_period; endproperty
    a_kdiv: assert property (p_kdiv) else $error("link period");
    property p_rdk; $fell(read_port_sel_n) |=> $rose(k); endproperty
    a_rdk: assert property (p_rdk) else $error("read off k rise");
    property p_wsel; $fell(write_port_sel_n) |-> (!write_port_sel_n)[*2]
        ##1 write_port_sel_n; endproperty
    a_wsel: assert property (p_wsel) else $error("write select");
    property p_rdq; $fell(read_port_sel_n) |-> ##[4:8] q_oe; endproperty
    a_rdq: assert property (p_rdq) else $error("read not driven");
    property p_len; $rose(q_oe) |-> s_burst; endproperty
    a_len: assert property (p_len) else $error("burst too short");
    property p_float; $rose(read_port_sel_n) ##1 read_port_sel_n[*8]
        ##1 read_port_sel_n[*4] |=> !q_oe; endproperty
    a_float: assert property (p_float) else $error("q not floated");
endmodule // bsspio_properties

/* dv/bsspio_tb_top.sv */
// Purpose: Runs bursts through both ends of the burst SRAM link.
// Assumes: Mode inputs change only while reset is held.
// Notes: A local copy of the array gives every expected read.
`timescale 1ns/100ps
module bsspio_tb_top;
    import bsspio_pkg::*;
    localparam int W = BURST_LEN * DATA_W;
    logic clk, rst_n, cmd_valid, cmd_ready, cmd_write, rd_valid, sc, lp;
    logic [ADDR_W-1:0] cmd_addr;
    logic [W-1:0] cmd_wdata, rd_data, d;
    logic [BURST_LEN*LANES-1:0] cmd_wsel_n;
    logic [W-1:0] ref_mem [MEM_DEPTH]; // Expected array contents.
    // Write and read addresses; top bits alias onto 16 locations.
    logic [ADDR_W-1:0] wa [4] =
        '{19'h00003, 19'h7ffff, 19'h00010, 19'h00005};
    logic [ADDR_W-1:0] ra [4] =
        '{19'h00003, 19'h0000f, 19'h00000, 19'h00005};
    int error_cnt, checks_done, cyc;
    bsspio_if lnk ();
    bsspio_dev i_bsspio_dev (.link(lnk), .rst_n(rst_n));
    bsspio_ctl i_bsspio_ctl (.link(lnk), .clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wsel_n(cmd_wsel_n),
        .rd_valid(rd_valid), .rd_data(rd_data), .cfg_single_clock(sc),
        .cfg_timing_loop_disable_n(lp));
    bsspio_properties i_bsspio_properties (.clk(clk), .rst_n(rst_n),
        .k(lnk.k), .k_n(lnk.k_n), .c(lnk.c), .q_oe(lnk.q_oe),
        .read_port_sel_n(lnk.read_port_sel_n),
        .echo_timebase(lnk.echo_timebase),
        .write_port_sel_n(lnk.write_port_sel_n),
        .single_clock_mode(lnk.single_clock_mode));
    // Counts one comparison and reports a mismatch at once.
    task automatic chk(string what, logic [W-1:0] exp, logic [W-1:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Holds one command until taken; a read then waits for its data.
    task automatic op(logic w, logic [ADDR_W-1:0] a, logic [W-1:0] wd,
        logic [BURST_LEN*LANES-1:0] s);
        int n;
        logic [MEM_IDX_W-1:0] x;
        x = a[MEM_IDX_W-1:0];
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= wd;
        cmd_wsel_n <= s;
        do @(posedge clk); while (cmd_ready !== 1'b1 && ++n < 20);
        cmd_valid <= 1'b0;
        chk("cmd_ready", W'(1'b1), W'(cmd_ready));
        for (n = 0; n < BURST_LEN * LANES; n++)
            if (w && !s[n]) ref_mem[x][n*9+:9] = wd[n*9+:9];
        n = 0;
        while (!w && rd_valid !== 1'b1 && n++ < 40) @(posedge clk);
        if (!w)
        begin
            chk("rd_valid", W'(1'b1), W'(rd_valid));
            chk("rd_data", ref_mem[x], rd_data);
            #1 chk("q_oe", W'(1'b0), W'(lnk.q_oe));
        end
    endtask
    always @(posedge clk)
        if (++cyc == 4000)
        begin
            error_cnt++;
            stop_test();
        end
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        {rst_n, cmd_valid, cmd_write, sc, lp, cmd_addr, cmd_wdata} = '0;
        cmd_wsel_n = '1;
        // Pass 0 runs with the loop off; pass 1 with loop and single clock.
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk);
            rst_n <= 1'b0;
            sc <= m[0];
            lp <= m[0];
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            for (int i = 0; i < 4; i++)
            begin
                d = {36'h3_3333_3330, 36'h2_2222_2220, 36'h1_1111_1110,
                    36'h0} + {4{36'(i + 4 * m)}};
                op(1'b1, wa[i], d, '0);
                op(1'b0, ra[i], '0, '1);
            end
            op(1'b1, wa[0], ~d, 16'ha5c3);
            op(1'b0, wa[0], '0, '1);
        end
        stop_test();
    end
endmodule // bsspio_tb_top
